/* scf_pkg.sv */
/*
  package for the sinc3 decimation filter: widths, counts, timing figures.
  assumes a single system clock REF_CLK at 25 MHz; the modulator bit clock
  and bit stream arrive as asynchronous pins sampled by that clock.
*/
// Overview of operation
// - the output follows a third-order sinc, the cube of a running sum over decimation_rate bits.
// - the integrator chain advances once per modulator bit, each stage adding its predecessor.
// - a high input bit counts as 1 and a low bit as 0 into the first integrator.
// - integrators update on the falling bit-clock edge and clear to zero under reset.
// - capturing on the rising bit-clock edge instead is a selectable option.
// - an 8-bit decimation counter steps on each rising bit-clock edge and clears under reset.
// - the word strobe is the counter's top bit, giving one word per 256 bits.
// - each rising word strobe loads the 16-bit output register.
// - the output carries bits 23 down to 8 of the final comb result.
// - each integrator holds its own previous value plus the preceding stage's value.
package scf_pkg;
  localparam int ACC_W      = 24;          // integrator and comb width
  localparam int OUT_W      = 16;          // output word width
  localparam int CNT_W      = 8;           // decimation counter width
  localparam int OUT_LSB    = 8;           // lowest result bit kept
  localparam int FIFO_DEPTH = 16;          // output word buffer depth
  localparam int SYNC_W     = 2;           // synchroniser stages
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [ACC_W-1:0] ACC_RST = 24'h00_0000;
  localparam logic [OUT_W-1:0] OUT_RST = 16'h0000;
  localparam int REF_CLK_NS = 40;          // system clock period
  localparam int BIT_CLK_NS = 320;         // nominal bit clock period
endpackage

/* scf_fifo.sv */
/*
  scf_fifo: flip-flop FIFO with valid/ready on both sides.
  assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module scf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,      // system clock
  input  wire logic             arst_n,   // async reset, active low
  input  wire logic             in_valid, // write request
  output logic                  in_ready, // space available
  input  wire logic [WIDTH-1:0] in_data,  // write data
  output logic                  out_valid,// word available
  input  wire logic             out_ready,// reader takes word
  output logic      [WIDTH-1:0] out_data  // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  // handshake terms
  assign in_ready  = (cnt_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // next pointers, count and storage
  always_comb begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    mem_next = mem_reg;
    if (push) begin
      mem_next[wr_reg] = in_data;
      wr_next = wr_reg + AW'(1);
    end
    if (pop) begin
      rd_next = rd_reg + AW'(1);
    end
    case ({push, pop})
      2'b10:   cnt_next = cnt_reg + (AW+1)'(1);
      2'b01:   cnt_next = cnt_reg - (AW+1)'(1);
      default: cnt_next = cnt_reg;
    endcase
  end

  // pointer and count registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage registers, one per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_mem
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        mem_reg[i] <= '0;
      end else begin
        mem_reg[i] <= mem_next[i];
      end
    end
  end
endmodule

/* scf_filter.sv */
/*
  scf_filter: sinc3 decimation filter for a single-bit modulator stream.
  assumes the modulator bit clock is at most REF_CLK/4 so that both of its
  edges are seen after a two-stage synchroniser; the bit stream is settled
  around the chosen capture edge.
*/
`timescale 1ns/1ps
module scf_filter (
  input  wire logic        REF_CLK,              // 25 MHz system clock
  input  wire logic        ARST_N,               // async reset, active low
  input  wire logic        MODULATOR_BIT_CLOCK,  // modulator bit clock pin
  input  wire logic        MODULATOR_BIT_STREAM, // modulator data pin
  input  wire logic        CAPTURE_ON_RISE,      // 1: integrate on rising edge
  output logic      [15:0] WORD_DATA,            // filtered output word
  output logic             WORD_VALID,           // fifo holds a word
  input  wire logic        WORD_READY,           // reader accepts word
  output logic             WORD_OVERRUN          // word dropped, fifo full
);
  localparam int AW = scf_pkg::ACC_W;
  localparam int CW = scf_pkg::CNT_W;
  localparam int OW = scf_pkg::OUT_W;

  logic [scf_pkg::SYNC_W-1:0] clk_sync_reg, clk_sync_next;
  logic [scf_pkg::SYNC_W-1:0] dat_sync_reg, dat_sync_next;
  logic [scf_pkg::SYNC_W-1:0] cap_sync_reg, cap_sync_next;
  logic                       clk_prev_reg, clk_prev_next;
  logic                       filter_bit_clock_in;
  logic                       filter_bit_in;
  logic                       rise, fall, int_step;
  logic [AW-1:0]              input_sample_value;
  logic [AW-1:0]              first_integrator_reg, first_integrator_next;
  logic [AW-1:0]              second_integrator_reg, second_integrator_next;
  logic [AW-1:0]              third_integrator_reg, third_integrator_next;
  logic [CW-1:0]              word_count_reg, word_count_next;
  logic                       strobe_prev_reg, strobe_prev_next;
  logic                       word_strobe, word_rise;
  logic [AW-1:0]              comb1_d_reg, comb1_d_next;
  logic [AW-1:0]              comb2_d_reg, comb2_d_next;
  logic [AW-1:0]              comb3_d_reg, comb3_d_next;
  logic [AW-1:0]              comb1, comb2, final_comb_result;
  logic [OW-1:0]              out_reg, out_next;
  logic                       load_reg, load_next;
  logic                       ovr_reg, ovr_next;
  logic                       fifo_in_ready;

  // two-flop synchronisers; only the last stage is read
  always_comb begin
    clk_sync_next = {clk_sync_reg[0], MODULATOR_BIT_CLOCK};
    dat_sync_next = {dat_sync_reg[0], MODULATOR_BIT_STREAM};
    cap_sync_next = {cap_sync_reg[0], CAPTURE_ON_RISE}; // edge-select pin
    clk_prev_next = clk_sync_reg[1];
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      clk_sync_reg <= '0;
      dat_sync_reg <= '0;
      cap_sync_reg <= '0;
      clk_prev_reg <= 1'b0;
    end else begin
      clk_sync_reg <= clk_sync_next;
      dat_sync_reg <= dat_sync_next;
      cap_sync_reg <= cap_sync_next;
      clk_prev_reg <= clk_prev_next;
    end
  end

  // bit-clock edge detection on the synchronised level
  assign filter_bit_clock_in = clk_sync_reg[1];
  assign filter_bit_in       = dat_sync_reg[1];
  assign rise = filter_bit_clock_in & ~clk_prev_reg;
  assign fall = ~filter_bit_clock_in & clk_prev_reg;
  assign int_step = cap_sync_reg[1] ? rise : fall;

  // input sample: one for a high bit, zero for a low bit
  assign input_sample_value = filter_bit_in ? AW'(1) : AW'(0);

  // integrator chain, one step per modulator bit, wrapping at 24 bits
  always_comb begin
    first_integrator_next  = first_integrator_reg;
    second_integrator_next = second_integrator_reg;
    third_integrator_next  = third_integrator_reg;
    if (int_step) begin
      first_integrator_next  = first_integrator_reg + input_sample_value;
      second_integrator_next = second_integrator_reg + first_integrator_reg;
      third_integrator_next  = third_integrator_reg + second_integrator_reg;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      first_integrator_reg  <= scf_pkg::ACC_RST;
      second_integrator_reg <= scf_pkg::ACC_RST;
      third_integrator_reg  <= scf_pkg::ACC_RST;
    end else begin
      first_integrator_reg  <= first_integrator_next;
      second_integrator_reg <= second_integrator_next;
      third_integrator_reg  <= third_integrator_next;
    end
  end

  // decimation counter on rising bit-clock edges; strobe is its top bit
  always_comb begin
    word_count_next  = rise ? word_count_reg + CW'(1) : word_count_reg;
    strobe_prev_next = word_strobe;
  end
  assign word_strobe = word_count_reg[CW-1];
  assign word_rise   = word_strobe & ~strobe_prev_reg;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      word_count_reg  <= scf_pkg::CNT_RST;
      strobe_prev_reg <= 1'b0;
    end else begin
      word_count_reg  <= word_count_next;
      strobe_prev_reg <= strobe_prev_next;
    end
  end

  // three comb stages evaluated at each word strobe rise
  assign comb1             = third_integrator_reg - comb1_d_reg;
  assign comb2             = comb1 - comb2_d_reg;
  assign final_comb_result = comb2 - comb3_d_reg;

  always_comb begin
    comb1_d_next = comb1_d_reg;
    comb2_d_next = comb2_d_reg;
    comb3_d_next = comb3_d_reg;
    out_next     = out_reg;
    load_next    = 1'b0;
    ovr_next     = ovr_reg;
    if (word_rise) begin
      comb1_d_next = third_integrator_reg;
      comb2_d_next = comb1;
      comb3_d_next = comb2;
      out_next     = final_comb_result[AW-1:scf_pkg::OUT_LSB];
      load_next    = 1'b1;
    end
    if (load_reg && !fifo_in_ready) begin
      ovr_next = 1'b1;
    end else if (load_reg) begin
      ovr_next = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      comb1_d_reg <= scf_pkg::ACC_RST;
      comb2_d_reg <= scf_pkg::ACC_RST;
      comb3_d_reg <= scf_pkg::ACC_RST;
      out_reg     <= scf_pkg::OUT_RST;
      load_reg    <= 1'b0;
      ovr_reg     <= 1'b0;
    end else begin
      comb1_d_reg <= comb1_d_next;
      comb2_d_reg <= comb2_d_next;
      comb3_d_reg <= comb3_d_next;
      out_reg     <= out_next;
      load_reg    <= load_next;
      ovr_reg     <= ovr_next;
    end
  end

  assign WORD_OVERRUN = ovr_reg;

  // output words wait in a 16-word buffer for the reader
  scf_fifo #(
    .WIDTH (OW),
    .DEPTH (scf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (REF_CLK),
    .arst_n    (ARST_N),
    .in_valid  (load_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (out_reg),
    .out_valid (WORD_VALID),
    .out_ready (WORD_READY),
    .out_data  (WORD_DATA)
  );
endmodule

/* scf_filter_chk.sv */
/* scf_filter_chk: port assertions for the sinc3 filter.
   assumes it is bound to scf_filter and sees its ports only. */
`timescale 1ns/1ps
module scf_filter_chk (
  input wire logic        REF_CLK,              // clock
  input wire logic        ARST_N,               // reset
  input wire logic        MODULATOR_BIT_CLOCK,  // bit clock
  input wire logic        MODULATOR_BIT_STREAM, // bit data
  input wire logic        CAPTURE_ON_RISE,      // edge select
  input wire logic [15:0] WORD_DATA,            // head word
  input wire logic        WORD_VALID,           // word ready
  input wire logic        WORD_READY,           // pop
  input wire logic        WORD_OVERRUN          // word lost
);
  logic [2:0] sync_reg;  // bit clock synchroniser copy
  logic [7:0] cnt_reg;   // rising bit edges seen
  logic [7:0] gap_reg;   // cycles since a word was made
  logic       made;      // counter passes 127 to 128
  assign made = sync_reg[1] & ~sync_reg[2] & (cnt_reg == 8'h7f);
  // edge counter wraps; word age saturates so it never wraps
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync_reg <= 3'h0;
      cnt_reg <= 8'h00;
      gap_reg <= 8'hff;
    end else begin
      sync_reg <= {sync_reg[1:0], MODULATOR_BIT_CLOCK};
      cnt_reg <= cnt_reg + {7'h00, sync_reg[1] & ~sync_reg[2]};
      gap_reg <= made ? 8'h00 : gap_reg + {7'h00, gap_reg != 8'hff};
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // outputs clear under reset, words follow the counter
  property p_reset; $rose(ARST_N) |-> !WORD_VALID && !WORD_OVERRUN
    && WORD_DATA == 16'h0000; endproperty
  a_reset: assert property (p_reset) else $error("reset state");
  property p_push; made |-> ##[1:8] WORD_VALID; endproperty
  a_push: assert property (p_push) else $error("no word");
  property p_vrise; $rose(WORD_VALID) |-> gap_reg <= 8'h08; endproperty
  a_vrise: assert property (p_vrise) else $error("stray word");
  property p_vfall; $fell(WORD_VALID) |-> $past(WORD_READY); endproperty
  a_vfall: assert property (p_vfall) else $error("word lost");
  property p_vhold; WORD_VALID && !WORD_READY |=> WORD_VALID; endproperty
  a_vhold: assert property (p_vhold) else $error("valid drop");
  property p_dhold; WORD_VALID && !WORD_READY |=> $stable(WORD_DATA);
  endproperty
  a_dhold: assert property (p_dhold) else $error("data moved");
  property p_orise; $rose(WORD_OVERRUN) |-> WORD_VALID
    && gap_reg <= 8'h08; endproperty
  a_orise: assert property (p_orise) else $error("stray overrun");
  property p_ofall; $fell(WORD_OVERRUN) |-> gap_reg <= 8'h08; endproperty
  a_ofall: assert property (p_ofall) else $error("overrun drop");
endmodule
bind scf_filter scf_filter_chk u_chk (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
  .MODULATOR_BIT_CLOCK(MODULATOR_BIT_CLOCK),
  .MODULATOR_BIT_STREAM(MODULATOR_BIT_STREAM),
  .CAPTURE_ON_RISE(CAPTURE_ON_RISE), .WORD_DATA(WORD_DATA),
  .WORD_VALID(WORD_VALID), .WORD_READY(WORD_READY),
  .WORD_OVERRUN(WORD_OVERRUN));

/* scf_mod_model.sv */
/* scf_mod_model: single-bit modulator with a free 320 ns bit clock.
   assumes density 0 gives all zeros and 256 all ones. */
`timescale 1ns/1ps
module scf_mod_model (
  output logic             bit_clk,  // modulator bit clock
  output logic             bit_dat,  // density-coded stream
  input  wire logic [8:0]  density   // ones per 256 bits
);
  // data moves mid-high so it is settled at both clock edges
  initial begin
    bit_clk = 1'b0;
    bit_dat = 1'b0;
    forever begin
      #160 bit_clk = 1'b1;
      #80 bit_dat = ($urandom_range(255, 0) < density);
      #80 bit_clk = 1'b0;
    end
  end
endmodule

/* tb_scf_filter.sv */
/* tb_scf_filter: self-checking bench for the sinc3 filter.
   assumes the modulator model and the bound checker beside it. */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  errors++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb_scf_filter;
  logic        REF_CLK, ARST_N, CAPTURE_ON_RISE, WORD_READY;
  logic        WORD_VALID, WORD_OVERRUN, bclk, bdat;
  logic [15:0] WORD_DATA, ex_w;
  logic [8:0]  dens;
  logic [23:0] a1, a2, a3, a3d, d1, d1d, d2, d2d, d3;
  logic [7:0]  cnt;
  logic [15:0] exp_q[$];
  logic [8:0]  dtab[6] = '{9'h100, 9'h100, 9'h000, 9'h080, 9'h001, 9'h0ff};
  int          errors, n_checks, nwords, cyc, rmode;
  scf_filter dut (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
    .MODULATOR_BIT_CLOCK(bclk), .MODULATOR_BIT_STREAM(bdat),
    .CAPTURE_ON_RISE(CAPTURE_ON_RISE), .WORD_DATA(WORD_DATA),
    .WORD_VALID(WORD_VALID), .WORD_READY(WORD_READY),
    .WORD_OVERRUN(WORD_OVERRUN));
  scf_mod_model u_mod (.bit_clk(bclk), .bit_dat(bdat), .density(dens));
  // clock
  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end
  task automatic complete_run;
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // reset, released just after a falling bit edge
  task automatic do_reset(input logic c);
    ARST_N = 1'b0;
    CAPTURE_ON_RISE = c;
    {a1, a2, a3, a3d, d1d, d2d, cnt} = '0;
    exp_q.delete();
    nwords = 0;
    repeat (2) @(negedge REF_CLK);
    @(negedge bclk);
    // bit edges share time steps with falling clock edges: step clear
    repeat (2) @(negedge REF_CLK);
    ARST_N = 1'b1;
  endtask
  // reference filter stepped on the bit clock pin edges
  always @(bclk) if (ARST_N === 1'b1) begin
    if (bclk === CAPTURE_ON_RISE) begin
      a3 = a3 + a2;
      a2 = a2 + a1;
      a1 = a1 + {23'h00_0000, bdat};
    end
    if (bclk) cnt = cnt + 8'h01;
    if (bclk && cnt == 8'h80) begin
      d1 = a3 - a3d;
      a3d = a3;
      d2 = d1 - d1d;
      d1d = d1;
      d3 = d2 - d2d;
      d2d = d2;
      nwords++;
      if (exp_q.size() < 16) exp_q.push_back(d3[23:8]);
    end
  end
  // reader side, random stalls
  always @(negedge REF_CLK)
    WORD_READY <= rmode == 2 || (rmode == 1 && $urandom_range(1, 0) == 1);
  // result watcher takes the oldest note per popped word
  always @(posedge REF_CLK)
    if (ARST_N === 1'b1 && WORD_VALID === 1'b1 && WORD_READY === 1'b1) begin
      ex_w = exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx;
      `CHK("word", ex_w, WORD_DATA)
    end
  // hang limit
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      complete_run();
    end
  end
  // falling capture with varied densities, then rising capture to overrun
  initial begin
    void'($urandom(32'h524d));
    {dens, rmode} = '0;
    do_reset(1'b0);
    rmode = 1;
    foreach (dtab[i]) begin
      dens = i == 5 ? 9'($urandom_range(256, 0)) : dtab[i];
      repeat (2048) @(negedge REF_CLK);
    end
    rmode = 0;
    do_reset(1'b1);
    wait (nwords >= 17);
    repeat (16) @(negedge REF_CLK);
    `CHK("overrun", 1'b1, WORD_OVERRUN)
    rmode = 2;
    wait (exp_q.size() == 0);
    repeat (4) @(negedge REF_CLK);
    `CHK("valid", 1'b0, WORD_VALID)
    wait (nwords >= 18);
    repeat (16) @(negedge REF_CLK);
    `CHK("overrun clear", 1'b0, WORD_OVERRUN)
    complete_run();
  end
endmodule
